// File: gcf_ctrl.sv
// Controller driving three-phase gate commands and the shared fault line
`timescale 1ns/1ns
module gcf_ctrl #(
  parameter int unsigned RESTART_CYC = gcf_pkg::RESTART_CYC,
  parameter int unsigned SD_CYC      = gcf_pkg::SD_PULSE_CYC,
  parameter int unsigned DUTY_W      = gcf_pkg::DUTY_W
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 run_i,
  input  wire logic                 shutdown_req_i,
  input  wire logic                 over_temp_i,
  input  wire logic [DUTY_W-1:0]    period_i,
  input  wire logic [DUTY_W-1:0]    duty_u_i,
  input  wire logic [DUTY_W-1:0]    duty_v_i,
  input  wire logic [DUTY_W-1:0]    duty_w_i,
  input  wire logic                 fault_line_i,
  output logic                      fault_line_o,
  output logic                      fault_line_oe_o,
  output gcf_pkg::gcf_cmd_t         cmd_o,
  output logic                      running_o,
  output logic                      fault_seen_o
);
  gcf_pkg::gcf_state_t state_q, state_d;
  logic                fl_s1_q, fl_s2_q;
  logic [31:0]         wait_q;
  logic [DUTY_W-1:0]   carrier_q, period_eff;
  logic [15:0]         sd_cnt_q;
  logic                sd_drive_q, fault_seen_q;
  logic                sd_d1_q, sd_d2_q;   // Delayed copies of our own line drive
  logic                line_low, en, sd_can_change;
  logic [2:0]          want_hi, hi_w, lo_w;
  gcf_pkg::gcf_cmd_t   cmd_q;

  // Fault line passes two flip-flops before use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fl_s1_q <= 1'b1;
      fl_s2_q <= 1'b1;
    end else begin
      fl_s1_q <= fault_line_i;
      fl_s2_q <= fl_s1_q;
    end
  end
  // Own drive delayed to match the synchroniser, so the line rising
  // after our own shutdown pulse is not taken for a device fault
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sd_d1_q <= 1'b0;
      sd_d2_q <= 1'b0;
    end else begin
      sd_d1_q <= sd_drive_q;
      sd_d2_q <= sd_d1_q;
    end
  end

  // Low while we are not pulling it ourselves is a device fault
  assign line_low = !fl_s2_q && !sd_drive_q && !sd_d1_q && !sd_d2_q;

  // Clamp carrier period into the 5 to 20 kHz band
  assign period_eff = (period_i < DUTY_W'(gcf_pkg::PERIOD_MIN_CYC)) ?
                      DUTY_W'(gcf_pkg::PERIOD_MIN_CYC) :
                      (period_i > DUTY_W'(gcf_pkg::PERIOD_MAX_CYC)) ?
                      DUTY_W'(gcf_pkg::PERIOD_MAX_CYC) : period_i;

  // Carrier counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) carrier_q <= '0;
    else if (carrier_q >= period_eff - DUTY_W'(1)) carrier_q <= '0;
    else carrier_q <= carrier_q + DUTY_W'(1);
  end

  assign want_hi = {carrier_q < duty_w_i, carrier_q < duty_v_i, carrier_q < duty_u_i};

  // Operating state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      gcf_pkg::ST_IDLE:  if (run_i && !over_temp_i && fl_s2_q) state_d = gcf_pkg::ST_RUN;
      gcf_pkg::ST_RUN: begin
        if (line_low) state_d = gcf_pkg::ST_FAULT;
        else if (!run_i || over_temp_i) state_d = gcf_pkg::ST_IDLE;
      end
      gcf_pkg::ST_FAULT: state_d = gcf_pkg::ST_WAIT;
      gcf_pkg::ST_WAIT:  if (wait_q >= RESTART_CYC - 1 && fl_s2_q) state_d = gcf_pkg::ST_IDLE;
      default:           state_d = gcf_pkg::ST_IDLE;
    endcase
  end

  // State and restart delay counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= gcf_pkg::ST_IDLE;
      wait_q  <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      wait_q  <= (state_q == gcf_pkg::ST_WAIT) ? wait_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Enable drops the same cycle a fault is seen
  assign en = (state_q == gcf_pkg::ST_RUN) && !line_low && !over_temp_i;

  // Controller-driven shutdown with 3 us minimum low and high
  assign sd_can_change = sd_cnt_q >= 16'(SD_CYC);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sd_drive_q <= 1'b0;
      sd_cnt_q   <= 16'h0000;
    end else if (sd_can_change && (shutdown_req_i != sd_drive_q)) begin
      sd_drive_q <= shutdown_req_i;
      sd_cnt_q   <= 16'h0000;
    end else if (sd_cnt_q != 16'hffff) begin
      sd_cnt_q   <= sd_cnt_q + 16'h0001;
    end
  end

  // Sticky fault indication until the restart wait ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) fault_seen_q <= 1'b0;
    else if (state_q == gcf_pkg::ST_FAULT) fault_seen_q <= 1'b1;
    else if (state_q == gcf_pkg::ST_IDLE) fault_seen_q <= 1'b0;
  end

  // Three independent phase generators
  for (genvar p = 0; p < 3; p++) begin : g_ph
    gcf_phase u_phase (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .en_i        (en),
      .want_high_i (want_hi[p]),
      .hi_o        (hi_w[p]),
      .lo_o        (lo_w[p])
    );
  end

  // Registered commands, always a definite level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cmd_q <= '0;
    else begin
      cmd_q.high_side_cmd_in <= hi_w & {3{en}};
      cmd_q.low_side_cmd_in  <= lo_w & {3{en}};
    end
  end

  assign cmd_o           = cmd_q;
  assign fault_line_o    = 1'b0;
  assign fault_line_oe_o = sd_drive_q;
  assign running_o       = (state_q == gcf_pkg::ST_RUN);
  assign fault_seen_o    = fault_seen_q;

  a_fault_cmds_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    line_low |-> ##2 (cmd_o == '0)) else $error("commands not low after fault");
  a_fault_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == gcf_pkg::ST_RUN) && line_low |=> state_q == gcf_pkg::ST_FAULT)
    else $error("fault did not stop run");
  a_sd_low_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(sd_drive_q) |-> sd_drive_q [*8]) else $error("shutdown pulse short");
  a_sd_high_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(sd_drive_q) |-> !sd_drive_q [*8]) else $error("shutdown gap short");
  a_restart_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == gcf_pkg::ST_WAIT) && (wait_q < 32'(RESTART_CYC - 1))
    |=> state_q != gcf_pkg::ST_IDLE)
    else $error("restart too early");
  // Wait is not left while the device still holds the line low
  a_wait_line: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == gcf_pkg::ST_WAIT) && !fl_s2_q |=> state_q != gcf_pkg::ST_IDLE)
    else $error("left wait with line low");
  // A foreign low level while running always leads to the fault state
  a_sync_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == gcf_pkg::ST_RUN) && !fl_s2_q && !sd_drive_q && !sd_d1_q && !sd_d2_q
    |=> state_q == gcf_pkg::ST_FAULT)
    else $error("line low not seen as fault");
  // The fault flag follows the fault state
  a_fault_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == gcf_pkg::ST_FAULT |=> fault_seen_q)
    else $error("fault flag not set");
  a_hot_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    over_temp_i |-> ##2 (cmd_o == '0)) else $error("no stop when hot");
  a_no_cross: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_o.high_side_cmd_in & cmd_o.low_side_cmd_in) == 3'b000)
    else $error("phase shoot through");
  a_carrier_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    carrier_q < DUTY_W'(gcf_pkg::PERIOD_MAX_CYC)) else $error("carrier out of band");

  c_run:      cover property (@(posedge clk_i) state_q == gcf_pkg::ST_RUN ##1 cmd_o != '0);
  c_fault:    cover property (@(posedge clk_i) state_q == gcf_pkg::ST_FAULT);
  c_shutdown: cover property (@(posedge clk_i) $rose(sd_drive_q));
  c_restart:  cover property (@(posedge clk_i)
    state_q == gcf_pkg::ST_WAIT ##1 state_q == gcf_pkg::ST_IDLE);
endmodule // gcf_ctrl

// File: gcf_pkg.sv
// Package for the gate command and fault controller
package gcf_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned DEAD_NS        = 2000;
  localparam int unsigned MIN_PULSE_NS   = 1500;
  localparam int unsigned SD_PULSE_NS    = 3000;
  localparam int unsigned PWM_MIN_KHZ    = 5;
  localparam int unsigned PWM_MAX_KHZ    = 20;
  localparam int unsigned RESTART_S      = 2;
  localparam int unsigned DEAD_CYC       = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MIN_PULSE_CYC  = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SD_PULSE_CYC   = (SD_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PERIOD_MIN_CYC = CLK_HZ / (PWM_MAX_KHZ * 1000);
  localparam int unsigned PERIOD_MAX_CYC = CLK_HZ / (PWM_MIN_KHZ * 1000);
  localparam int unsigned RESTART_CYC    = RESTART_S * CLK_HZ;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned DUTY_W         = 16;

  // Per-phase gate commands toward the module
  typedef struct packed {
    logic [2:0] high_side_cmd_in;
    logic [2:0] low_side_cmd_in;
  } gcf_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAULT = 2'b10,
    ST_WAIT  = 2'b11
  } gcf_state_t;
endpackage

// File: gcf_phase.sv
// One phase of complementary PWM with dead time and minimum pulse width
`timescale 1ns/1ns
module gcf_phase #(
  parameter int unsigned DEAD_CYC  = gcf_pkg::DEAD_CYC,
  parameter int unsigned MIN_CYC   = gcf_pkg::MIN_PULSE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      en_i,
  input  wire logic                      want_high_i,
  output logic                           hi_o,
  output logic                           lo_o
);
  logic        hi_q, lo_q;
  logic [15:0] age_q;        // Cycles since last output change
  logic        dead_ok, min_ok, go_hi, go_lo, go_off;

  assign dead_ok = age_q >= 16'(DEAD_CYC);
  assign min_ok  = age_q >= 16'(MIN_CYC);
  // Off is immediate when disabled; switching on waits for dead time
  assign go_off  = !en_i && (hi_q || lo_q);
  assign go_hi   = en_i && want_high_i && !hi_q && !lo_q && dead_ok;
  assign go_lo   = en_i && !want_high_i && !lo_q && !hi_q && dead_ok;

  // Output state and pulse age counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      age_q <= 16'h0000;
    end else if (go_off) begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      age_q <= 16'h0000;
    end else if (en_i && min_ok && ((hi_q && !want_high_i) || (lo_q && want_high_i))) begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      age_q <= 16'h0000;
    end else if (go_hi || go_lo) begin
      hi_q  <= go_hi;
      lo_q  <= go_lo;
      age_q <= 16'h0000;
    end else if (age_q != 16'hffff) begin
      age_q <= age_q + 16'h0001;
    end
  end

  assign hi_o = hi_q;
  assign lo_o = lo_q;

  a_no_overlap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(hi_q && lo_q)) else $error("high and low on together");
  a_dead_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(hi_q) |-> !lo_q [*8]) else $error("dead time too short");
  // A high pulse may only end early when the phase is disabled
  a_min_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(hi_q) && $past(en_i) |-> $past(age_q) >= 16'(MIN_CYC)) else $error("short pulse");
endmodule // gcf_phase

// File: gcf_dev_model.sv
// Behavioural model of the gate drive module seen from its command and fault pins
`timescale 1ns/1ns
module gcf_dev_model #(
  parameter int HOLD_CYC = 200,
  parameter int FILT_CYC = 125,
  parameter int OCP_CYC  = 15
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire gcf_pkg::gcf_cmd_t cmd_i,
  input  wire logic              line_i,
  input  wire logic              ocp_i,
  input  wire logic              uvlo_i,
  output logic                   pull_o,
  output logic [2:0]             hi_gate_o,
  output logic [2:0]             lo_gate_o
);
  int         ocp_q;
  int         hold_q;
  int         filt_q;
  logic [2:0] hin_q;
  wire        trip_w = ocp_q >= OCP_CYC;
  wire        low_w  = filt_q >= FILT_CYC;
  // Pull the shared line on lockout or during the hold time
  assign pull_o    = uvlo_i | trip_w | (hold_q > 0);
  assign lo_gate_o = (low_w | pull_o) ? 3'h0 : cmd_i.low_side_cmd_in;
  // Sense filter, hold timer, line filter and high-side edge latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ocp_q     <= 0;
      hold_q    <= 0;
      filt_q    <= 0;
      hin_q     <= 3'h0;
      hi_gate_o <= 3'h0;
    end else begin
      ocp_q     <= ocp_i ? ocp_q + 1 : 0;
      hold_q    <= trip_w ? HOLD_CYC : (hold_q > 0 ? hold_q - 1 : 0);
      filt_q    <= line_i ? 0 : filt_q + 1;
      hin_q     <= cmd_i.high_side_cmd_in;
      hi_gate_o <= (hi_gate_o | (cmd_i.high_side_cmd_in & ~hin_q))
                   & ~(~cmd_i.high_side_cmd_in & hin_q);
    end
  end
endmodule  // gcf_dev_model

// File: gate_command_fault_interface_tb.sv
// Self-checking bench for the gate command and fault controller
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module gate_command_fault_interface_tb;
  logic              clk_i, rst_n_i, run_i, sd_i, hot_i, ocp_i, uvlo_i, steady;
  logic [15:0]       period_i;
  logic [15:0]       duty_q [3];
  logic              fault_line_o, fault_line_oe_o, running_o, fault_seen_o, pull_w;
  gcf_pkg::gcf_cmd_t cmd_o;
  logic [2:0]        hq, lq;
  int                idle_c [3], hon_c [3], oe_c, gap_c, cyc, last_u, span_u, n;
  int                fail_count, num_checks;
  logic [31:0]       seed, pv [3];
  wire               line_w = !((fault_line_oe_o & !fault_line_o) | pull_w);
  wire [2:0]         hi = cmd_o.high_side_cmd_in;
  wire [2:0]         lo = cmd_o.low_side_cmd_in;

  gcf_ctrl #(.RESTART_CYC(500)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_i),
    .shutdown_req_i(sd_i), .over_temp_i(hot_i), .period_i(period_i), .duty_u_i(duty_q[0]),
    .duty_v_i(duty_q[1]), .duty_w_i(duty_q[2]), .fault_line_i(line_w),
    .fault_line_o(fault_line_o), .fault_line_oe_o(fault_line_oe_o), .cmd_o(cmd_o),
    .running_o(running_o), .fault_seen_o(fault_seen_o));
  gcf_dev_model dev_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_o), .line_i(line_w),
    .ocp_i(ocp_i), .uvlo_i(uvlo_i), .pull_o(pull_w), .hi_gate_o(), .lo_gate_o());

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int clampp(input int v);
    return v < gcf_pkg::PERIOD_MIN_CYC ? gcf_pkg::PERIOD_MIN_CYC
         : (v > gcf_pkg::PERIOD_MAX_CYC ? gcf_pkg::PERIOD_MAX_CYC : v);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Watch of dead gap, pulse width, carrier span and shutdown widths
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
    for (int p = 0; p < 3; p++) begin
      `CHK("overlap", 1'b0, hi[p] & lo[p])
      if (steady && (hi[p] || lo[p]) && !hq[p] && !lq[p]) `CHK("dead gap", 1'b1, idle_c[p] >= gcf_pkg::DEAD_CYC)
      if (steady && hq[p] && !hi[p]) `CHK("high pulse", 1'b1, hon_c[p] >= gcf_pkg::MIN_PULSE_CYC)
      idle_c[p] = (hi[p] || lo[p]) ? 0 : idle_c[p] + 1;
      hon_c[p]  = hi[p] ? hon_c[p] + 1 : 0;
    end
    if (rst_n_i) `CHK("cmd driven", 1'b0, $isunknown(cmd_o))
    if (hi[0] && !hq[0]) begin
      span_u = cyc - last_u;
      last_u = cyc;
    end
    if (!fault_line_oe_o && oe_c > 0) `CHK("sd low width", 1'b1, oe_c >= gcf_pkg::SD_PULSE_CYC)
    if (fault_line_oe_o && gap_c > 0) `CHK("sd high width", 1'b1, gap_c >= gcf_pkg::SD_PULSE_CYC)
    oe_c  = fault_line_oe_o ? oe_c + 1 : 0;
    gap_c = fault_line_oe_o ? 0 : gap_c + 1;
    hq    = hi;
    lq    = lo;
  end
  // Main sequence
  initial begin
    {rst_n_i, run_i, sd_i, hot_i, ocp_i, uvlo_i, steady} = 7'h0;
    {cyc, last_u, span_u, fail_count, num_checks, oe_c} = 0;
    gap_c = 1000;
    seed = 32'd69731;
    period_i = 16'h0;
    for (int i = 0; i < 3; i++) duty_q[i] = 16'(300 + rnd() % 1700);
    tick(16);
    rst_n_i <= 1'b1;
    pv = '{32'd1000, 32'd2500 + rnd() % 5000, 32'hffff};
    period_i <= pv[0][15:0];
    run_i  <= 1'b1;
    steady <= 1'b1;
    tick(3);
    `CHK("running", 1'b1, running_o)
    for (int i = 0; i < 3; i++) begin
      period_i <= pv[i][15:0];
      tick(3 * clampp(pv[i]) + 400);
      `CHK("carrier span", clampp(pv[i]), span_u)
    end
    period_i <= 16'd2500;
    steady <= 1'b0;
    hot_i  <= 1'b1;
    tick(4);
    `CHK("hot stop", 1'b0, running_o)
    `CHK("hot cmd", 6'h0, cmd_o)
    hot_i <= 1'b0;
    for (n = 0; n < 1000 && running_o !== 1'b1; n++) tick(1);
    for (int k = 0; k < 2; k++) begin
      steady <= 1'b0;
      if (k == 1) ocp_i <= 1'b1;
      else uvlo_i <= 1'b1;
      tick(24);
      `CHK("fault cmd", 6'h0, cmd_o)
      `CHK("fault seen", 1'b1, fault_seen_o)
      ocp_i  <= 1'b0;
      uvlo_i <= 1'b0;
      for (n = 0; n < 400 && line_w !== 1'b1; n++) tick(1);
      tick(30);
      `CHK("restart hold", 1'b0, running_o)
      for (n = 0; n < 1000 && running_o !== 1'b1; n++) tick(1);
      `CHK("restart", 1'b1, running_o)
      steady <= 1'b1;
    end
    sd_i <= 1'b1;
    tick(3);
    `CHK("sd drive", 1'b1, fault_line_oe_o)
    `CHK("sd level", 1'b0, fault_line_o)
    sd_i <= 1'b0;
    tick(5);
    sd_i <= 1'b1;
    tick(5);
    sd_i <= 1'b0;
    tick(700);
    `CHK("sd no fault", 1'b1, running_o)
    `CHK("sd no flag", 1'b0, fault_seen_o)
    complete_run();
  end
endmodule  // gate_command_fault_interface_tb
